// file: design/bpe_event_logic.sv
`timescale 1ns/1ps
module bpe_event_logic
   import bpe_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire bpe_reg_req_t reg_req,
   output logic [31:0] reg_rdata,
   input wire bpe_branch_t br,
   output logic [BPE_NCNT-1:0] cnt_inc,
   output logic redirect_seq,
   output bpe_tgt_src_t tgt_src
);

   function automatic logic bpe_cfg_hit(logic [7:0] addr, int idx);
      logic [7:0] ofs;
      ofs = BPE_CFG0_OFS + BPE_CFG_STEP * idx[7:0];
      return addr == ofs;
   endfunction

   function automatic logic bpe_count_sel(logic [31:0] cfg, logic [BPE_EVW-1:0] ev, logic slot_hit,
                                          logic iar, logic opc);
      logic [7:0] code;
      logic [3:0] umask;
      logic pick;
      code = cfg[BPE_CODE_LSB +: BPE_CODE_W];
      umask = cfg[BPE_UMASK_LSB +: BPE_UMASK_W];
      pick = ((code == BPE_EV_PRED) & ev[umask]) | ((code == BPE_EV_SLOT) & slot_hit);
      return pick & (~cfg[BPE_IAR_BIT] | iar) & (~cfg[BPE_OPC_BIT] | opc);
   endfunction

   logic [31:0] cfg [BPE_NCNT];
   logic [BPE_EVW-1:0] ev_last;
   logic [31:0] next_rdata;
   bpe_tgt_src_t next_tgt_src;

   wire logic v;
   wire logic s1;
   wire logic s1_live;
   wire logic s1_ok;
   wire logic s1_path;
   wire logic s1_tgt;
   wire logic s2_ok;
   wire logic s2_nt;
   wire logic s2_tk;
   wire logic s2_pred;
   wire logic s2_good;
   wire logic s2_path;
   wire logic s2_tgt;
   wire logic s3_loop;
   wire logic s3_comp;
   wire logic s3_hint;
   wire logic s3_pred;
   wire logic s3_tk;
   wire logic s3_good;
   wire logic s3_path;
   wire logic s3_tgt;
   wire logic next_redirect;
   wire logic [BPE_EVW-1:0] ev;
   wire logic [BPE_NCNT-1:0] slot_hit;
   wire logic [BPE_NCNT-1:0] next_inc;

   // First stage
   assign v = br.valid;
   assign s1 = v & br.s1_hit;
   assign s1_live = s1 & ~br.loop_last;
   assign s1_ok = s1_live & br.actual_taken & br.target_ok;
   assign s1_path = s1_live & ~br.actual_taken;
   assign s1_tgt = s1_live & br.actual_taken & ~br.target_ok;

   // Second stage acts only when the first stage made no prediction
   assign s2_ok = v & ~br.s1_hit;
   assign s2_nt = s2_ok & br.tbl_hit & ~br.tbl_taken;
   assign s2_tk = s2_ok & (br.tbl_hit ? (br.tbl_taken & (br.is_return | br.tac_hit)) : br.tac_hit);
   assign s2_pred = s2_nt | s2_tk;
   assign s2_good = (s2_nt & ~br.actual_taken) | (s2_tk & br.actual_taken & br.target_ok);
   assign s2_path = (s2_nt & br.actual_taken) | (s2_tk & ~br.actual_taken);
   assign s2_tgt = s2_tk & br.actual_taken & ~br.target_ok;

   // Third stage address calculator
   assign s3_loop = s1 & br.loop_last;
   assign s3_comp = s2_ok & br.tbl_hit & br.tbl_taken & ~br.tac_hit & ~br.is_return;
   assign s3_hint = s2_ok & ~br.tbl_hit & ~br.tac_hit;
   assign s3_pred = s3_loop | s3_comp | s3_hint;
   assign s3_tk = s3_comp | (s3_hint & br.hint_taken);
   assign s3_good = (s3_tk & br.actual_taken & br.target_ok)
                  | ((s3_loop | (s3_hint & ~br.hint_taken)) & ~br.actual_taken);
   assign s3_path = (s3_hint & (br.hint_taken ^ br.actual_taken)) | (s3_comp & ~br.actual_taken);
   assign s3_tgt = s3_tk & br.actual_taken & ~br.target_ok;

   // Fetch steering from the third stage
   assign next_redirect = s3_loop | (s3_hint & ~br.hint_taken);

   always_comb begin
      next_tgt_src = BPE_TGT_NONE;
      if (s3_comp) begin
         next_tgt_src = BPE_TGT_COMPUTE;
      end else if (s3_hint & br.hint_taken) begin
         next_tgt_src = br.kind_indirect ? BPE_TGT_RETSTACK : BPE_TGT_COMPUTE;
      end
   end

   // One bit per unit mask, each a single event of weight one
   assign ev = {s3_tgt, s3_path, s3_good, s3_pred,
                s2_tgt, s2_path, s2_good, s2_pred,
                s1_tgt, s1_path, s1_ok, s1,
                4'h0};

   genvar gi;
   generate
      for (gi = 0; gi < BPE_NCNT; gi++) begin : g_cnt
         bpe_slot_classify u_slot (
            .valid(v),
            .slot_taken(br.slot_taken),
            .slot_mask(cfg[gi][BPE_UMASK_LSB +: BPE_UMASK_W]),
            .hit(slot_hit[gi])
         );
         assign next_inc[gi] = bpe_count_sel(cfg[gi], ev, slot_hit[gi], br.iar_match, br.opc_match);
         always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
               cfg[gi] <= BPE_CFG_RST;
            end else if (reg_req.wr && bpe_cfg_hit(reg_req.addr, gi)) begin
               cfg[gi] <= reg_req.wdata & BPE_CFG_WMASK;
            end
         end
      end
   endgenerate

   // Register read decode
   always_comb begin
      next_rdata = BPE_ZERO;
      if (!reg_req.rd) begin
         next_rdata = BPE_ZERO;
      end else if (bpe_cfg_hit(reg_req.addr, 0)) begin
         next_rdata = cfg[0];
      end else if (bpe_cfg_hit(reg_req.addr, 1)) begin
         next_rdata = cfg[1];
      end else if (bpe_cfg_hit(reg_req.addr, 2)) begin
         next_rdata = cfg[2];
      end else if (bpe_cfg_hit(reg_req.addr, 3)) begin
         next_rdata = cfg[3];
      end else if (reg_req.addr == BPE_STAT_OFS) begin
         next_rdata = {16'h0000, ev_last};
      end else if (reg_req.addr == BPE_OUT_OFS) begin
         next_rdata = {24'h00_0000, 1'b0, tgt_src, redirect_seq, 3'h0};
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         reg_rdata <= BPE_ZERO;
         ev_last <= 16'h0000;
         cnt_inc <= 4'h0;
         redirect_seq <= 1'b0;
         tgt_src <= BPE_TGT_NONE;
      end else begin
         reg_rdata <= next_rdata;
         ev_last <= ev;
         cnt_inc <= next_inc;
         redirect_seq <= next_redirect;
         tgt_src <= next_tgt_src;
      end
   end

   // Checks on counter 0, the increment vector and the steering outputs
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   wire logic [7:0] c0_code;
   wire logic [3:0] c0_um;
   wire logic c0_plain;
   assign c0_code = cfg[0][BPE_CODE_LSB +: BPE_CODE_W];
   assign c0_um = cfg[0][BPE_UMASK_LSB +: BPE_UMASK_W];
   assign c0_plain = ~cfg[0][BPE_IAR_BIT] & ~cfg[0][BPE_OPC_BIT];

   sequence s_c0_pred(logic [3:0] um);
      c0_plain && (c0_code == BPE_EV_PRED) && (c0_um == um);
   endsequence

   sequence s_c0_slot(logic [3:0] um);
      c0_plain && (c0_code == BPE_EV_SLOT) && (c0_um == um);
   endsequence

   sequence s_tbl_taken_nocache;
      br.valid && !br.s1_hit && br.tbl_hit && br.tbl_taken && !br.is_return && !br.tac_hit;
   endsequence

   chk_s1_all_count: assert property (
      s_c0_pred(BPE_UM_S1_ALL) ##0 (br.valid && br.s1_hit) |=> cnt_inc[0])
      else $error("first-stage prediction not counted");

   chk_s1_correct_count: assert property (
      s_c0_pred(BPE_UM_S1_OK) ##0 (br.valid && br.s1_hit && !br.loop_last)
      |=> cnt_inc[0] == $past(br.actual_taken && br.target_ok))
      else $error("first-stage correct count wrong");

   chk_s1_path_loop: assert property (
      s_c0_pred(BPE_UM_S1_PATH) ##0 (br.valid && br.s1_hit && br.loop_last) |=> !cnt_inc[0])
      else $error("loop override counted as first-stage wrong path");

   chk_s1_wrong_tgt: assert property (
      s_c0_pred(BPE_UM_S1_TGT) ##0 (br.valid && br.s1_hit && !br.loop_last && br.actual_taken
      && !br.target_ok) |=> cnt_inc[0])
      else $error("first-stage wrong target missed");

   chk_s2_after_s1: assert property (
      s_c0_pred(BPE_UM_S2_ALL) ##0 (br.valid && br.s1_hit) |=> !cnt_inc[0])
      else $error("second stage counted after first-stage hit");

   chk_s2_nocache_skip: assert property (
      s_c0_pred(BPE_UM_S2_ALL) ##0 s_tbl_taken_nocache |=> !cnt_inc[0])
      else $error("cache-missed taken counted in second stage");

   chk_s2_correct_excl: assert property (
      s_c0_pred(BPE_UM_S2_OK) ##0 s_tbl_taken_nocache ##0 br.actual_taken |=> !cnt_inc[0])
      else $error("calculator-target branch counted as second-stage correct");

   chk_s2_wrong_path: assert property (
      s_c0_pred(BPE_UM_S2_PATH) ##0 (br.valid && !br.s1_hit && br.tbl_hit && !br.tbl_taken
      && br.actual_taken) |=> cnt_inc[0])
      else $error("second-stage not-taken misprediction missed");

   chk_s3_compute_count: assert property (
      s_c0_pred(BPE_UM_S3_ALL) ##0 s_tbl_taken_nocache
      |=> cnt_inc[0] && (tgt_src == BPE_TGT_COMPUTE) && !redirect_seq)
      else $error("third-stage computed target not counted");

   chk_loop_redirect: assert property (
      (br.valid && br.s1_hit && br.loop_last) |=> redirect_seq ##1 !redirect_seq || $past(next_redirect))
      else $error("loop exit did not redirect to sequential path");

   chk_hint_target: assert property (
      (br.valid && !br.s1_hit && !br.tbl_hit && !br.tac_hit && br.hint_taken)
      |=> (tgt_src == ($past(br.kind_indirect) ? BPE_TGT_RETSTACK : BPE_TGT_COMPUTE)) && !redirect_seq)
      else $error("hint-taken target source wrong");

   chk_hint_path: assert property (
      s_c0_pred(BPE_UM_S3_PATH) ##0 (br.valid && !br.s1_hit && !br.tbl_hit && !br.tac_hit
      && (br.hint_taken != br.actual_taken)) |=> cnt_inc[0])
      else $error("hint misprediction not counted");

   chk_slot_first: assert property (
      s_c0_slot(4'h2) ##0 (br.valid && br.slot_taken[0]) |=> !cnt_inc[0])
      else $error("slot 1 counted behind taken slot 0");

   chk_slot_none: assert property (
      s_c0_slot(4'h8) ##0 br.valid |=> cnt_inc[0] == ($past(br.slot_taken) == 3'b000))
      else $error("no-taken bundle count wrong");

   chk_inc_needs_valid: assert property (
      !br.valid |=> cnt_inc == 4'h0)
      else $error("increment without a bundle");

   chk_s1_only_taken: assert property (
      s_c0_pred(BPE_UM_S1_ALL) ##0 (br.valid && !br.s1_hit) |=> !cnt_inc[0])
      else $error("first-stage count without a first-stage hit");

   chk_s2_return_count: assert property (
      s_c0_pred(BPE_UM_S2_ALL) ##0 (br.valid && !br.s1_hit && br.tbl_hit && br.tbl_taken && br.is_return)
      |=> cnt_inc[0])
      else $error("taken return not counted in second stage");

   chk_s2_correct_nt: assert property (
      s_c0_pred(BPE_UM_S2_OK) ##0 (br.valid && !br.s1_hit && br.tbl_hit && !br.tbl_taken)
      |=> cnt_inc[0] == $past(!br.actual_taken))
      else $error("second-stage correct not-taken count wrong");

   chk_s2_wrong_tgt: assert property (
      s_c0_pred(BPE_UM_S2_TGT) ##0 (br.valid && !br.s1_hit && !br.tbl_hit && br.tac_hit
      && br.actual_taken && !br.target_ok) |=> cnt_inc[0])
      else $error("second-stage wrong target missed");

   chk_s3_hint_count: assert property (
      s_c0_pred(BPE_UM_S3_ALL) ##0 (br.valid && !br.s1_hit && !br.tbl_hit && !br.tac_hit)
      |=> cnt_inc[0])
      else $error("hint-based prediction not counted");

   chk_s3_skip_stage2: assert property (
      s_c0_pred(BPE_UM_S3_ALL) ##0 (br.valid && !br.s1_hit && br.tbl_hit && !br.tbl_taken)
      |=> !cnt_inc[0])
      else $error("second-stage not-taken counted in third stage");

   chk_hint_redirect: assert property (
      (br.valid && !br.s1_hit && !br.tbl_hit && !br.tac_hit && !br.hint_taken)
      |=> redirect_seq && (tgt_src == BPE_TGT_NONE))
      else $error("hint not-taken did not follow sequential path");

   chk_s3_loop_correct: assert property (
      s_c0_pred(BPE_UM_S3_OK) ##0 (br.valid && br.s1_hit && br.loop_last)
      |=> cnt_inc[0] == $past(!br.actual_taken))
      else $error("loop override correct count wrong");

   chk_s3_wrong_tgt: assert property (
      s_c0_pred(BPE_UM_S3_TGT) ##0 s_tbl_taken_nocache ##0 (br.actual_taken && !br.target_ok)
      |=> cnt_inc[0])
      else $error("calculator wrong target missed");

   chk_slot_zero: assert property (
      s_c0_slot(4'h1) ##0 (br.valid && br.slot_taken[0]) |=> cnt_inc[0])
      else $error("taken slot 0 not counted");

   chk_slot_or: assert property (
      s_c0_slot(4'h5) ##0 (br.valid && (br.slot_taken == 3'b100)) |=> cnt_inc[0])
      else $error("selected slot cases not combined");

   chk_qual_block: assert property (
      (c0_code == BPE_EV_PRED) && (c0_um == BPE_UM_S1_ALL) && cfg[0][BPE_IAR_BIT] && br.valid
      && !br.iar_match |=> !cnt_inc[0])
      else $error("address qualifier did not block the count");

   chk_idle_quiet: assert property (
      !br.valid |=> !redirect_seq && (tgt_src == BPE_TGT_NONE))
      else $error("steering output without a bundle");

   chk_tgt_onehot: assert property (
      $onehot(tgt_src))
      else $error("target source not one-hot");

endmodule

// file: design/bpe_pkg.sv
package bpe_pkg;

   // Number of general counters fed by this block
   localparam int BPE_NCNT = 4;
   localparam int BPE_AW = 8;
   localparam int BPE_DW = 32;
   localparam int BPE_EVW = 16;

   // Register offsets (byte addresses)
   localparam logic [7:0] BPE_CFG0_OFS = 8'h00;
   localparam logic [7:0] BPE_CFG_STEP = 8'h04;
   localparam logic [7:0] BPE_STAT_OFS = 8'h10;
   localparam logic [7:0] BPE_OUT_OFS = 8'h14;

   // Counter configuration layout
   localparam int BPE_CODE_LSB = 0;
   localparam int BPE_CODE_W = 8;
   localparam int BPE_UMASK_LSB = 16;
   localparam int BPE_UMASK_W = 4;
   localparam int BPE_IAR_BIT = 20;
   localparam int BPE_OPC_BIT = 21;
   localparam logic [31:0] BPE_CFG_RST = 32'h0000_0000;
   localparam logic [31:0] BPE_CFG_WMASK = 32'h003F_00FF;
   localparam logic [31:0] BPE_ZERO = 32'h0000_0000;

   // Event codes
   localparam logic [7:0] BPE_EV_PRED = 8'h10;
   localparam logic [7:0] BPE_EV_SLOT = 8'h0D;

   // Unit masks under the prediction event group
   localparam logic [3:0] BPE_UM_S1_ALL = 4'h4;
   localparam logic [3:0] BPE_UM_S1_OK = 4'h5;
   localparam logic [3:0] BPE_UM_S1_PATH = 4'h6;
   localparam logic [3:0] BPE_UM_S1_TGT = 4'h7;
   localparam logic [3:0] BPE_UM_S2_ALL = 4'h8;
   localparam logic [3:0] BPE_UM_S2_OK = 4'h9;
   localparam logic [3:0] BPE_UM_S2_PATH = 4'hA;
   localparam logic [3:0] BPE_UM_S2_TGT = 4'hB;
   localparam logic [3:0] BPE_UM_S3_ALL = 4'hC;
   localparam logic [3:0] BPE_UM_S3_OK = 4'hD;
   localparam logic [3:0] BPE_UM_S3_PATH = 4'hE;
   localparam logic [3:0] BPE_UM_S3_TGT = 4'hF;

   // Slot-select bits of the taken-slot event
   localparam int BPE_SLOT0_BIT = 0;
   localparam int BPE_SLOT1_BIT = 1;
   localparam int BPE_SLOT2_BIT = 2;
   localparam int BPE_NONE_BIT = 3;

   // One resolved branch bundle per cycle from the front end
   typedef struct packed {
      logic valid;
      logic s1_hit;
      logic loop_last;
      logic tbl_hit;
      logic tbl_taken;
      logic is_return;
      logic tac_hit;
      logic hint_taken;
      logic kind_indirect;
      logic actual_taken;
      logic target_ok;
      logic [2:0] slot_taken;
      logic iar_match;
      logic opc_match;
   } bpe_branch_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } bpe_reg_req_t;

   typedef enum logic [2:0] {
      BPE_TGT_NONE = 3'b001,
      BPE_TGT_RETSTACK = 3'b010,
      BPE_TGT_COMPUTE = 3'b100
   } bpe_tgt_src_t;

endpackage

// file: design/bpe_slot_classify.sv
`timescale 1ns/1ps
module bpe_slot_classify
   import bpe_pkg::*;
(
   input wire logic valid,
   input wire logic [2:0] slot_taken,
   input wire logic [3:0] slot_mask,
   output logic hit
);
   wire logic first0;
   wire logic first1;
   wire logic first2;
   wire logic none_taken;

   assign first0 = slot_taken[0];
   assign first1 = ~slot_taken[0] & slot_taken[1];
   assign first2 = ~slot_taken[0] & ~slot_taken[1] & slot_taken[2];
   assign none_taken = ~|slot_taken;

   // Every selected case is ORed into one outcome
   assign hit = valid & ((slot_mask[BPE_SLOT0_BIT] & first0)
                       | (slot_mask[BPE_SLOT1_BIT] & first1)
                       | (slot_mask[BPE_SLOT2_BIT] & first2)
                       | (slot_mask[BPE_NONE_BIT] & none_taken));
endmodule

// file: testbench/bpe_front_model.sv
`timescale 1ns/1ps
module bpe_front_model
   import bpe_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire bpe_branch_t req,
   input wire logic req_vld,
   output bpe_branch_t br
);
   bpe_branch_t next_br;

   // Idle cycles scramble stale fields so no old bundle lingers
   always_comb begin
      next_br = req_vld ? req : ~br;
      if (!req_vld) begin
         next_br.valid = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         br <= '0;
      end else begin
         br <= next_br;
      end
   end
endmodule

// file: testbench/bpe_event_logic_tb.sv
`timescale 1ns/1ps
module bpe_event_logic_tb
   import bpe_pkg::*;
;
   logic clk = 1'b0;
   logic reset = 1'b1;
   bpe_reg_req_t reg_req = '0;
   logic [31:0] reg_rdata;
   bpe_branch_t req = '0;
   logic req_vld = 1'b0;
   bpe_branch_t br;
   logic [BPE_NCNT-1:0] cnt_inc;
   logic redirect_seq;
   bpe_tgt_src_t tgt_src;
   logic [31:0] cfg [BPE_NCNT];
   int num_errors = 0;
   int checks = 0;
   int cycles = 0;

   always #2.5 clk = ~clk;

   bpe_front_model u_front (.clk(clk), .reset(reset), .req(req), .req_vld(req_vld), .br(br));
   bpe_event_logic DUT (.clk(clk), .reset(reset), .reg_req(reg_req), .reg_rdata(reg_rdata), .br(br),
      .cnt_inc(cnt_inc), .redirect_seq(redirect_seq), .tgt_src(tgt_src));

   task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   function automatic logic [31:0] pm(input logic [7:0] code, input logic [3:0] m);
      return {12'h000, m, 8'h00, code};
   endfunction

   function automatic logic exp_inc(input bpe_branch_t b, input logic [31:0] c);
      logic s1, t, ok, nt, tk, lp, cp, hn, ht, ev;
      logic [3:0] m;
      logic [2:0] s;
      m = c[19:16];
      s = b.slot_taken;
      s1 = b.s1_hit & !b.loop_last;
      t = b.actual_taken;
      ok = b.target_ok;
      ht = b.hint_taken;
      nt = !b.s1_hit & b.tbl_hit & !b.tbl_taken;
      tk = !b.s1_hit & (b.tbl_hit ? b.tbl_taken & (b.is_return | b.tac_hit) : b.tac_hit);
      lp = b.s1_hit & b.loop_last;
      cp = !b.s1_hit & b.tbl_hit & b.tbl_taken & !b.tac_hit & !b.is_return;
      hn = !b.s1_hit & !b.tbl_hit & !b.tac_hit;
      case (m)
         4'h4: ev = b.s1_hit;
         4'h5: ev = s1 & t & ok;
         4'h6: ev = s1 & !t;
         4'h7: ev = s1 & t & !ok;
         4'h8: ev = nt | tk;
         4'h9: ev = nt & !t | tk & t & ok;
         4'hA: ev = nt & t | tk & !t;
         4'hB: ev = tk & t & !ok;
         4'hC: ev = lp | cp | hn;
         4'hD: ev = (cp | hn & ht) & t & ok | (lp | hn & !ht) & !t;
         4'hE: ev = hn & (ht != t) | cp & !t;
         4'hF: ev = (cp | hn & ht) & t & !ok;
         default: ev = 1'b0;
      endcase
      if (c[7:0] == BPE_EV_SLOT)
         ev = m[0] & s[0] | m[1] & !s[0] & s[1] | m[2] & s == 3'b100 | m[3] & s == 3'b000;
      else if (c[7:0] != BPE_EV_PRED)
         ev = 1'b0;
      return b.valid & ev & (!c[20] | b.iar_match) & (!c[21] | b.opc_match);
   endfunction

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      reg_req.wr <= 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      reg_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      reg_req.rd <= 1'b0;
      #1;
      chk_word("reg_rdata", exp, reg_rdata);
      @(posedge clk);
      #1;
      chk_word("reg_rdata after", 32'h0000_0000, reg_rdata);
   endtask

   task automatic set_cfg(input logic [31:0] c0, c1, c2, c3);
      cfg = '{c0, c1, c2, c3};
      for (int i = 0; i < BPE_NCNT; i++)
         reg_wr(BPE_CFG0_OFS + BPE_CFG_STEP * 8'(i), cfg[i]);
   endtask

   // One bundle through the front end, then outputs and the idle cycle after
   task automatic send(input bpe_branch_t b);
      logic [BPE_NCNT-1:0] e;
      logic rs;
      bpe_tgt_src_t ts;
      for (int i = 0; i < BPE_NCNT; i++)
         e[i] = exp_inc(b, cfg[i]);
      rs = b.valid & (b.s1_hit & b.loop_last | !b.s1_hit & !b.tbl_hit & !b.tac_hit & !b.hint_taken);
      ts = BPE_TGT_NONE;
      if (b.valid & !b.s1_hit & (b.tbl_hit ? b.tbl_taken & !b.tac_hit & !b.is_return : !b.tac_hit & b.hint_taken))
         ts = (!b.tbl_hit & b.kind_indirect) ? BPE_TGT_RETSTACK : BPE_TGT_COMPUTE;
      @(posedge clk);
      req <= b;
      req_vld <= 1'b1;
      @(posedge clk);
      req_vld <= 1'b0;
      @(posedge clk);
      #1;
      chk_word("cnt_inc", 32'(e), 32'(cnt_inc));
      chk_word("redirect_seq", 32'(rs), 32'(redirect_seq));
      chk_word("tgt_src", 32'(ts), 32'(tgt_src));
      @(posedge clk);
      #1;
      chk_word("cnt_inc idle", 32'h0000_0000, 32'(cnt_inc));
   endtask

   // One bundle, then a register read sampled while its result stands
   task automatic rd_after(input bpe_branch_t b, input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      req <= b;
      req_vld <= 1'b1;
      @(posedge clk);
      req_vld <= 1'b0;
      @(posedge clk);
      reg_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      reg_req.rd <= 1'b0;
      #1;
      chk_word("reg_rdata", exp, reg_rdata);
   endtask

   // Each mask of a group takes a turn on counter 0, where the design's checks look
   task automatic sweep_group(input logic [3:0] base);
      logic [3:0] m;
      for (int r = 0; r < BPE_NCNT; r++) begin
         m = base + 4'(r);
         set_cfg(pm(BPE_EV_PRED, m), pm(BPE_EV_PRED, m ^ 4'h1),
            pm(BPE_EV_PRED, m ^ 4'h2), pm(BPE_EV_PRED, m ^ 4'h3));
         sweep();
      end
   endtask

   task automatic sweep();
      bpe_branch_t b;
      for (int k = 0; k < 1024; k++) begin
         b = '0;
         {b.s1_hit, b.loop_last, b.tbl_hit, b.tbl_taken, b.is_return, b.tac_hit, b.hint_taken,
            b.kind_indirect, b.actual_taken, b.target_ok} = 10'(k);
         b.valid = 1'b1;
         send(b);
      end
   endtask

   task automatic t_regs();
      for (int i = 0; i < BPE_NCNT; i++)
         reg_rd(BPE_CFG0_OFS + BPE_CFG_STEP * 8'(i), BPE_CFG_RST);
      reg_wr(8'h04, 32'hFFFF_FFFF);
      reg_rd(8'h04, BPE_CFG_WMASK);
      reg_wr(8'h40, 32'hFFFF_FFFF);
      reg_rd(8'h40, BPE_ZERO);
      reg_rd(8'h08, BPE_ZERO);
   endtask

   task automatic t_stage1();
      sweep_group(BPE_UM_S1_ALL);
   endtask

   task automatic t_stage2();
      sweep_group(BPE_UM_S2_ALL);
   endtask

   task automatic t_stage3();
      sweep_group(BPE_UM_S3_ALL);
   endtask

   task automatic t_slot();
      bpe_branch_t b;
      b = '0;
      set_cfg(pm(BPE_EV_SLOT, 4'h1), pm(BPE_EV_SLOT, 4'h2), pm(BPE_EV_SLOT, 4'h4), pm(BPE_EV_SLOT, 4'h8));
      for (int s = 0; s < 32; s++) begin
         if (s == 8)
            set_cfg(pm(BPE_EV_SLOT, 4'h5), pm(BPE_EV_SLOT, 4'hA), pm(BPE_EV_SLOT, 4'hF), pm(BPE_EV_SLOT, 4'h0));
         if (s == 16)
            set_cfg(pm(BPE_EV_SLOT, 4'h2), pm(BPE_EV_SLOT, 4'h1), pm(BPE_EV_SLOT, 4'h8), pm(BPE_EV_SLOT, 4'h4));
         if (s == 24)
            set_cfg(pm(BPE_EV_SLOT, 4'h8), pm(BPE_EV_SLOT, 4'h4), pm(BPE_EV_SLOT, 4'h2), pm(BPE_EV_SLOT, 4'h1));
         b.valid = (s != 15);
         b.slot_taken = 3'(s);
         send(b);
      end
   endtask

   task automatic t_qual();
      bpe_branch_t b;
      b = '0;
      set_cfg(pm(BPE_EV_PRED, 4'h4) | 32'h0010_0000, pm(BPE_EV_PRED, 4'h4) | 32'h0020_0000,
         pm(BPE_EV_PRED, 4'h4) | 32'h0030_0000, pm(8'h0F, 4'h4));
      for (int q = 0; q < 5; q++) begin
         b.valid = (q != 4);
         b.s1_hit = 1'b1;
         {b.iar_match, b.opc_match} = 2'(q);
         send(b);
      end
   endtask

   // Status and output registers hold one bundle's result for one cycle
   task automatic t_status();
      bpe_branch_t b;
      logic [31:0] e;
      for (int n = 0; n < 2; n++) begin
         b = '0;
         b.valid = 1'b1;
         b.s1_hit = (n == 1);
         b.loop_last = (n == 1);
         b.hint_taken = (n == 0);
         b.kind_indirect = (n == 0);
         b.actual_taken = (n == 0);
         b.target_ok = (n == 0);
         e = '0;
         for (int m = 4; m < 16; m++)
            e[m] = exp_inc(b, pm(BPE_EV_PRED, 4'(m)));
         rd_after(b, BPE_STAT_OFS, e);
         rd_after(b, BPE_OUT_OFS, (n == 0) ? 32'h0000_0020 : 32'h0000_0018);
      end
   endtask

   task automatic results();
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         num_errors++;
         results();
      end
   end

   initial begin
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      t_regs();
      t_stage1();
      t_stage2();
      t_stage3();
      t_slot();
      t_qual();
      t_status();
      results();
   end
endmodule
